// [rtl/nor_host_pkg.sv]
package nor_host_pkg;

   localparam int CLK_PERIOD_NS     = 10;

   // Timing figures in ns; plain defaults, adjust to the part in use
   localparam int T_RST_PULSE_NS    = 500;
   localparam int T_RST_TO_SEL_NS   = 200;
   localparam int T_RST_TO_WR_NS    = 200;
   localparam int T_ADDR_SETUP_NS   = 10;
   localparam int T_ACCESS_NS       = 100;
   localparam int T_WR_PULSE_NS     = 50;
   localparam int T_WR_HOLD_NS      = 10;
   localparam int T_RECOVER_NS      = 20;

   localparam int CNT_W             = 16;
   localparam int SYNC_LAT          = 2;

   // Least time to cycles: round up, never below one
   function automatic int min_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int RST_PULSE_CYC     = min_cycles(T_RST_PULSE_NS);
   localparam int RST_WAIT_CYC      = (T_RST_TO_SEL_NS > T_RST_TO_WR_NS) ?
                                      min_cycles(T_RST_TO_SEL_NS) :
                                      min_cycles(T_RST_TO_WR_NS);
   localparam int SETUP_CYC         = min_cycles(T_ADDR_SETUP_NS);
   localparam int ACCESS_CYC        = min_cycles(T_ACCESS_NS) + SYNC_LAT;
   localparam int WR_PULSE_CYC      = min_cycles(T_WR_PULSE_NS);
   localparam int WR_HOLD_CYC       = min_cycles(T_WR_HOLD_NS);
   localparam int RECOVER_CYC       = min_cycles(T_RECOVER_NS);

   localparam int ADDR_W            = 26;
   localparam int DATA_W            = 16;
   localparam int DENSITY_MBIT_DEF  = 1024;
   localparam int DENS_A23_MBIT     = 256;
   localparam int DENS_A24_MBIT     = 512;
   localparam int DENS_A25_MBIT     = 1024;
   localparam int STATUS_KEEP_BITS  = 8;

   typedef struct packed {
      logic                write;
      logic                status;
      logic [ADDR_W:0]     addr;
      logic [DATA_W-1:0]   wdata;
   } nor_req_t;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic rst_n;
   } nor_ctl_t;

   typedef struct packed {
      logic [7:0] lo;
      logic [6:0] hi;
      logic       d15;
   } nor_oe_t;

endpackage

// [rtl/sync2.sv]
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// [rtl/nor_flash_host.sv]
// Contract
// - Host holds width select steady during writes and never floats it.
// - Reset pin held low long enough resets device into standby.
// - Host waits the longer reset-release delay before any access.
// - Host ignores upper data bits when reading status polling register.
// - Address on later falling strobe edge, data on earlier rising edge.
// - Host keeps output enable high throughout every write.
module nor_flash_host #(
   parameter int DENSITY_MBIT = nor_host_pkg::DENSITY_MBIT_DEF
) (
   input  wire logic                   mclk,
   input  wire logic                   rstn,
   input  wire logic                   byte_mode,
   input  wire logic                   unprotect,
   input  wire logic                   reset_req,
   input  wire nor_host_pkg::nor_req_t req,
   input  wire logic                   req_valid,
   output logic                        req_ready,
   output logic                        rsp_valid,
   output logic [15:0]                 rsp_rdata,
   output logic                        dev_busy,
   output logic                        link_ready,
   output nor_host_pkg::nor_ctl_t      ctl,
   output logic                        bus_width_sel,
   output logic                        protect_boost_pin,
   output logic [22:0]                 addr_lines,
   output logic                        addr_bit_23,
   output logic                        addr_bit_24,
   output logic                        addr_bit_25,
   input  wire logic [7:0]             lower_data_bits_i,
   output logic [7:0]                  lower_data_bits_o,
   input  wire logic [6:0]             upper_data_bits_i,
   output logic [6:0]                  upper_data_bits_o,
   input  wire logic                   data15_or_addr_lsb_i,
   output logic                        data15_or_addr_lsb_o,
   output nor_host_pkg::nor_oe_t       data_oe,
   input  wire logic                   op_active_n
);

   typedef enum logic [8:0] {
      S_RST_HOLD = 9'h001,
      S_RST_WAIT = 9'h002,
      S_IDLE     = 9'h004,
      S_RD_SETUP = 9'h008,
      S_RD_WAIT  = 9'h010,
      S_WR_SETUP = 9'h020,
      S_WR_PULSE = 9'h040,
      S_WR_HOLD  = 9'h080,
      S_RECOVER  = 9'h100
   } state_t;

   typedef struct packed {
      state_t                          st;
      logic [nor_host_pkg::CNT_W-1:0]  cnt;
      logic                            status;
      logic                            byte_m;
      logic                            wide;
      logic                            wp;
      nor_host_pkg::nor_ctl_t          ctl;
      logic [25:0]                     addr;
      logic                            lsb;
      logic [15:0]                     wdata;
      nor_host_pkg::nor_oe_t           oe;
      logic                            ready;
      logic                            rsp;
      logic [15:0]                     rdata;
      logic                            busy;
      logic                            up;
   } host_state_t;

   localparam logic [nor_host_pkg::CNT_W-1:0] C_RST_PULSE =
      nor_host_pkg::CNT_W'(nor_host_pkg::RST_PULSE_CYC - 1);
   localparam logic [nor_host_pkg::CNT_W-1:0] C_RST_WAIT =
      nor_host_pkg::CNT_W'(nor_host_pkg::RST_WAIT_CYC - 1);
   localparam logic [nor_host_pkg::CNT_W-1:0] C_SETUP =
      nor_host_pkg::CNT_W'(nor_host_pkg::SETUP_CYC - 1);
   localparam logic [nor_host_pkg::CNT_W-1:0] C_ACCESS =
      nor_host_pkg::CNT_W'(nor_host_pkg::ACCESS_CYC - 1);
   localparam logic [nor_host_pkg::CNT_W-1:0] C_WR_PULSE =
      nor_host_pkg::CNT_W'(nor_host_pkg::WR_PULSE_CYC - 1);
   localparam logic [nor_host_pkg::CNT_W-1:0] C_WR_HOLD =
      nor_host_pkg::CNT_W'(nor_host_pkg::WR_HOLD_CYC - 1);
   localparam logic [nor_host_pkg::CNT_W-1:0] C_RECOVER =
      nor_host_pkg::CNT_W'(nor_host_pkg::RECOVER_CYC - 1);

   localparam logic USE_A23 = DENSITY_MBIT >= nor_host_pkg::DENS_A23_MBIT;
   localparam logic USE_A24 = DENSITY_MBIT >= nor_host_pkg::DENS_A24_MBIT;
   localparam logic USE_A25 = DENSITY_MBIT >= nor_host_pkg::DENS_A25_MBIT;

   host_state_t s_q;
   host_state_t s_d;
   logic        rst_n_s;
   logic [15:0] din_s;
   logic        busy_s;

   sync2 #(.W(1)) u_rst_sync (
      .mclk  (mclk),
      .rst_n (rstn),
      .d     (1'b1),
      .q     (rst_n_s)
   );

   // Pin data and busy are asynchronous to mclk
   sync2 #(.W(17)) u_pin_sync (
      .mclk  (mclk),
      .rst_n (rst_n_s),
      .d     ({~op_active_n, data15_or_addr_lsb_i,
               upper_data_bits_i, lower_data_bits_i}),
      .q     ({busy_s, din_s})
   );

   function automatic logic cnt_done(input logic [15:0] c);
      return c == '0;
   endfunction

   always_comb begin
      s_d      = s_q;
      s_d.rsp  = 1'b0;
      s_d.busy = busy_s;
      if (!cnt_done(s_q.cnt)) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
      unique case (s_q.st)
         S_RST_HOLD: begin
            s_d.ctl = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0};
            if (cnt_done(s_q.cnt)) begin
               s_d.st        = S_RST_WAIT;
               s_d.cnt       = C_RST_WAIT;
               s_d.ctl.rst_n = 1'b1;
            end
         end
         S_RST_WAIT: begin
            if (cnt_done(s_q.cnt)) begin
               s_d.st    = S_IDLE;
               s_d.ready = 1'b1;
               s_d.up    = 1'b1;
            end
         end
         S_IDLE: begin
            // Width and protect change only between cycles
            s_d.byte_m = byte_mode;
            s_d.wide   = !byte_mode;
            // In x8 the shared pin is an address input, never left floating
            s_d.oe.d15 = byte_mode;
            s_d.wp     = unprotect;
            if (reset_req) begin
               s_d.st    = S_RST_HOLD;
               s_d.cnt   = C_RST_PULSE;
               s_d.ready = 1'b0;
               s_d.up    = 1'b0;
               s_d.ctl.rst_n = 1'b0;
            end else if (req_valid) begin
               s_d.ready  = 1'b0;
               s_d.status = req.status;
               s_d.wdata  = req.wdata;
               s_d.cnt    = C_SETUP;
               // Byte address in both widths; x16 drops bit 0
               s_d.addr = req.addr[26:1];
               s_d.lsb  = byte_mode ? req.addr[0] : req.wdata[15];
               s_d.addr[23] = req.addr[24] & USE_A23;
               s_d.addr[24] = req.addr[25] & USE_A24;
               s_d.addr[25] = req.addr[26] & USE_A25;
               s_d.ctl.ce_n = 1'b0;
               if (req.write) begin
                  s_d.st = S_WR_SETUP;
                  s_d.oe.lo  = 8'hFF;
                  s_d.oe.hi  = byte_mode ? 7'h00 : 7'h7F;
                  s_d.oe.d15 = 1'b1;
               end else begin
                  s_d.st = S_RD_SETUP;
                  s_d.oe.lo  = 8'h00;
                  s_d.oe.hi  = 7'h00;
                  s_d.oe.d15 = byte_mode;
               end
            end
         end
         S_RD_SETUP: begin
            if (cnt_done(s_q.cnt)) begin
               s_d.st       = S_RD_WAIT;
               s_d.cnt      = C_ACCESS;
               s_d.ctl.oe_n = 1'b0;
            end
         end
         S_RD_WAIT: begin
            if (cnt_done(s_q.cnt)) begin
               s_d.rdata = s_q.byte_m ? {8'h00, din_s[7:0]} :
                           {din_s[15], din_s[14:0]};
               if (s_q.status) begin
                  s_d.rdata[15:nor_host_pkg::STATUS_KEEP_BITS] = '0;
               end
               s_d.rsp      = 1'b1;
               s_d.ctl.oe_n = 1'b1;
               s_d.ctl.ce_n = 1'b1;
               s_d.st       = S_RECOVER;
               s_d.cnt      = C_RECOVER;
            end
         end
         S_WR_SETUP: begin
            if (cnt_done(s_q.cnt)) begin
               // Strobe falls after select: address caught here
               s_d.st       = S_WR_PULSE;
               s_d.cnt      = C_WR_PULSE;
               s_d.ctl.we_n = 1'b0;
            end
         end
         S_WR_PULSE: begin
            if (cnt_done(s_q.cnt)) begin
               // Strobe rises before select: data caught here
               s_d.st       = S_WR_HOLD;
               s_d.cnt      = C_WR_HOLD;
               s_d.ctl.we_n = 1'b1;
            end
         end
         S_WR_HOLD: begin
            if (cnt_done(s_q.cnt)) begin
               s_d.st       = S_RECOVER;
               s_d.cnt      = C_RECOVER;
               s_d.ctl.ce_n = 1'b1;
               s_d.oe       = '0;
               s_d.oe.d15   = s_q.byte_m;
               s_d.rsp      = 1'b1;
            end
         end
         S_RECOVER: begin
            // Every pin pulse lasts whole cycles, far above glitch width
            if (cnt_done(s_q.cnt)) begin
               s_d.st    = S_IDLE;
               s_d.ready = 1'b1;
               s_d.oe.d15 = s_q.byte_m;
            end
         end
      endcase
      // Read enable never low while writing
      if (s_q.st inside {S_WR_SETUP, S_WR_PULSE, S_WR_HOLD}) begin
         s_d.ctl.oe_n = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         s_q       <= '0;
         s_q.st    <= S_RST_HOLD;
         s_q.cnt   <= C_RST_PULSE;
         s_q.wide  <= 1'b1;
         s_q.ctl   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign req_ready            = s_q.ready;
   assign rsp_valid            = s_q.rsp;
   assign rsp_rdata            = s_q.rdata;
   assign dev_busy             = s_q.busy;
   assign link_ready           = s_q.up;
   assign ctl                  = s_q.ctl;
   assign bus_width_sel        = s_q.wide;
   assign protect_boost_pin    = s_q.wp;
   assign addr_lines           = s_q.addr[22:0];
   assign addr_bit_23          = s_q.addr[23];
   assign addr_bit_24          = s_q.addr[24];
   assign addr_bit_25          = s_q.addr[25];
   assign lower_data_bits_o    = s_q.wdata[7:0];
   assign upper_data_bits_o    = s_q.wdata[14:8];
   assign data15_or_addr_lsb_o = s_q.lsb;
   assign data_oe              = s_q.oe;

endmodule

// [verif/nor_host_sva.sv]
module nor_host_sva #(
   parameter int DENSITY_MBIT = nor_host_pkg::DENSITY_MBIT_DEF
) (
   input wire logic                   mclk,
   input wire logic                   rstn,
   input wire nor_host_pkg::nor_ctl_t ctl,
   input wire logic                   bus_width_sel,
   input wire nor_host_pkg::nor_oe_t  data_oe,
   input wire logic [22:0]            addr_lines,
   input wire logic [7:0]             lower_data_bits_o,
   input wire logic                   addr_bit_25,
   input wire logic                   rsp_valid,
   input wire logic [15:0]            rsp_rdata,
   input wire logic                   op_active_n,
   input wire logic                   dev_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking dclk @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic [15:0] low_q;
   logic [15:0] up_q;
   // up_q saturates, so a long idle spell never wraps below the wait figure
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         low_q <= 16'h0000;
         up_q  <= 16'h0000;
      end else begin
         low_q <= ctl.rst_n ? 16'h0000 : low_q + 16'h0001;
         up_q  <= !ctl.rst_n ? 16'h0000 : (&up_q ? up_q : up_q + 16'h0001);
      end
   end
   oe_high_write_a: assert property (!ctl.we_n |-> ctl.oe_n)
      else $error("output enable low in write");
   width_steady_a: assert property ($past(!ctl.ce_n) && !ctl.ce_n
      |-> $stable(bus_width_sel)) else $error("width select moved");
   rst_pulse_len_a: assert property ($rose(ctl.rst_n)
      |-> int'(low_q) >= nor_host_pkg::RST_PULSE_CYC)
      else $error("reset pulse too short");
   rst_wait_a: assert property ($fell(ctl.ce_n)
      |-> int'(up_q) >= nor_host_pkg::RST_WAIT_CYC)
      else $error("access too soon after reset");
   we_rise_first_a: assert property ($rose(ctl.we_n) |-> !ctl.ce_n)
      else $error("select rose before strobe");
   wr_hold_a: assert property (!ctl.we_n && $past(!ctl.we_n)
      |-> $stable(addr_lines) && $stable(lower_data_bits_o))
      else $error("address or data moved in strobe");
   no_contend_a: assert property (!ctl.oe_n |-> data_oe.lo == 8'h00
      && data_oe.hi == 7'h00 && (!bus_width_sel || !data_oe.d15))
      else $error("host drives data while reading");
   lsb_drive_a: assert property (!ctl.ce_n && !bus_width_sel
      |-> data_oe.d15) else $error("byte address bit not driven");
   byte_upper_a: assert property (rsp_valid && !bus_width_sel
      |-> rsp_rdata[15:8] == 8'h00) else $error("upper byte in byte mode");
   busy_follow_a: assert property ($fell(op_active_n)
      |-> ##[1:4] dev_busy) else $error("busy not reported");
   top_addr_a: assert property (DENSITY_MBIT < nor_host_pkg::DENS_A25_MBIT
      |-> !addr_bit_25) else $error("reserved address pin driven");
   cover property ($rose(ctl.rst_n));
   cover property (!ctl.we_n && !bus_width_sel);
   cover property (rsp_valid && !bus_width_sel);
   cover property ($fell(op_active_n));
endmodule

bind nor_flash_host nor_host_sva #(.DENSITY_MBIT(DENSITY_MBIT)) i_sva (
   .mclk(mclk), .rstn(rstn), .ctl(ctl), .bus_width_sel(bus_width_sel),
   .data_oe(data_oe), .addr_lines(addr_lines),
   .lower_data_bits_o(lower_data_bits_o), .addr_bit_25(addr_bit_25),
   .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
   .op_active_n(op_active_n), .dev_busy(dev_busy));

// [verif/nor_flash_model.sv]
module nor_flash_model #(
   parameter logic [7:0] PROG_CMD = 8'hA0,
   parameter int         ACC_NS   = 90,
   parameter int         BUSY_NS  = 2000
) (
   input  wire nor_host_pkg::nor_ctl_t ctl,
   input  wire logic                   bus_width_sel,
   input  wire logic                   protect_boost_pin,
   input  wire logic                   supply_low,
   input  wire logic [25:0]            a_pins,
   input  wire logic [15:0]            dq,
   output logic      [15:0]            dq_dev,
   output logic                        op_active_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [25:0] cap_addr;
   logic [7:0]  cap_cmd;
   logic [15:0] word;
   logic        valid = 1'b0;
   logic        busy = 1'b0;
   wire         rd;
   wire         wr;
   event        prog_ev;
   // Inertial delay swallows control glitches under 3 ns
   assign #3 rd = !ctl.ce_n && !ctl.oe_n && ctl.we_n
                  && ctl.rst_n;
   assign #3 wr = !ctl.ce_n && !ctl.we_n && ctl.rst_n;
   // Fixed mix of low address bits; reserved top pins never looked at
   always_comb begin
      word = a_pins[15:0] ^ 16'h5A3C;
      if (!bus_width_sel)
         word = {8'h00, dq[15] ? word[15:8] : word[7:0]};
   end
   always @(posedge rd) begin
      valid = 1'b0;
      #ACC_NS valid = rd;
   end
   always @(negedge rd) valid = 1'b0;
   // Released pins flip on each read event so no stale value passes
   always @(rd or valid) begin
      if (!(rd && valid)) dq_dev = ~dq_dev;
      else if (bus_width_sel) dq_dev = word;
      else dq_dev = {~dq_dev[15:8], word[7:0]};
   end
   initial dq_dev = 16'hA5A5;
   always @(posedge wr) cap_addr = a_pins;
   always @(negedge wr) begin
      cap_cmd = dq[7:0];
      if (cap_cmd == PROG_CMD && (protect_boost_pin || cap_addr[22:16] != 7'h00))
         -> prog_ev;
   end
   always @(prog_ev) begin
      busy = 1'b1;
      #BUSY_NS busy = 1'b0;
   end
   always @(posedge supply_low or negedge ctl.rst_n) busy = 1'b0;
   assign op_active_n = busy ? 1'b0 : 1'b1;
endmodule

// [verif/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DENS = 512;
   localparam int UP_MIN = nor_host_pkg::RST_PULSE_CYC
                           + nor_host_pkg::RST_WAIT_CYC;
   logic mclk, rstn, byte_mode, unprotect, reset_req, req_valid, supply_low;
   logic req_ready, rsp_valid, dev_busy, link_ready, bus_width_sel;
   logic protect_boost_pin, a23, a24, a25, op_active_n, d15_o;
   logic [15:0] rsp_rdata, dq, dq_dev;
   logic [22:0] addr_lines;
   logic [7:0]  lo_o;
   logic [6:0]  hi_o;
   nor_host_pkg::nor_req_t req;
   nor_host_pkg::nor_ctl_t ctl;
   nor_host_pkg::nor_oe_t  data_oe;
   int err_total = 0;
   int n_compared = 0;
   assign dq = ({data_oe.d15, data_oe.hi, data_oe.lo} & {d15_o, hi_o, lo_o})
               | (~{data_oe.d15, data_oe.hi, data_oe.lo} & dq_dev);
   nor_flash_host #(.DENSITY_MBIT(DENS)) i_dut (
      .mclk(mclk), .rstn(rstn), .byte_mode(byte_mode), .unprotect(unprotect),
      .reset_req(reset_req), .req(req), .req_valid(req_valid),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .dev_busy(dev_busy), .link_ready(link_ready), .ctl(ctl),
      .bus_width_sel(bus_width_sel), .protect_boost_pin(protect_boost_pin),
      .addr_lines(addr_lines), .addr_bit_23(a23), .addr_bit_24(a24),
      .addr_bit_25(a25), .lower_data_bits_i(dq[7:0]),
      .lower_data_bits_o(lo_o), .upper_data_bits_i(dq[14:8]),
      .upper_data_bits_o(hi_o), .data15_or_addr_lsb_i(dq[15]),
      .data15_or_addr_lsb_o(d15_o), .data_oe(data_oe),
      .op_active_n(op_active_n));
   nor_flash_model i_flash (.ctl(ctl), .bus_width_sel(bus_width_sel),
      .protect_boost_pin(protect_boost_pin), .supply_low(supply_low),
      .a_pins({a25, a24, a23, addr_lines}), .dq(dq), .dq_dev(dq_dev),
      .op_active_n(op_active_n));
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic fail(input string m);
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask
   task automatic bail();
      fail("wait bound used up");
      end_of_test();
   endtask
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) fail($sformatf("data %h exp %h", g, e));
   endtask
   task automatic chka(input logic [25:0] g, input logic [25:0] e);
      n_compared++;
      if (g !== e) fail($sformatf("addr %h exp %h", g, e));
   endtask
   task automatic chkb(input logic g, input logic e);
      n_compared++;
      if (g !== e) fail($sformatf("flag %b exp %b", g, e));
   endtask
   task automatic xfer(input logic w, input logic s, input logic [26:0] a,
                       input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      req       <= '{write: w, status: s, addr: a, wdata: d};
      req_valid <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (req_ready !== 1'b1 && n < 100);
      req_valid <= 1'b0;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 200);
      q = rsp_rdata;
      if (n >= 200) bail();
   endtask
   task automatic wait_up(output int n);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (!(link_ready === 1'b1 && req_ready === 1'b1) && n < 500);
      if (n >= 500) bail();
   endtask
   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (dev_busy !== v && n < lim) begin
         @(posedge mclk);
         n++;
      end
      chkb(dev_busy, v);
      if (n >= lim) bail();
   endtask
   task automatic set_mode(input logic b, input logic p);
      @(posedge mclk);
      byte_mode <= b;
      unprotect <= p;
      repeat (3) @(posedge mclk);
   endtask
   task automatic t_read_word();
      logic [15:0] q;
      set_mode(1'b0, 1'b0);
      xfer(1'b0, 1'b0, 27'h0002468, 16'h0000, q);
      chk16(q, 16'h4808);
      xfer(1'b0, 1'b0, 27'h001FFFE, 16'h0000, q);
      chk16(q, 16'hA5C3);
      xfer(1'b0, 1'b1, 27'h0002468, 16'h0000, q);
      chk16(q, 16'h0008);
   endtask
   task automatic t_read_byte();
      logic [15:0] q;
      set_mode(1'b1, 1'b0);
      xfer(1'b0, 1'b0, 27'h0001235, 16'h0000, q);
      chk16(q, 16'h0053);
   endtask
   task automatic t_write();
      logic [15:0] q;
      set_mode(1'b0, 1'b0);
      xfer(1'b1, 1'b0, 27'h4000ACE, 16'hBEEF, q);
      chka(i_flash.cap_addr, 26'h0000567);
      chk16({8'h00, i_flash.cap_cmd}, 16'h00EF);
      set_mode(1'b1, 1'b0);
      xfer(1'b1, 1'b0, 27'h0000ACF, 16'h1255, q);
      chka(i_flash.cap_addr, 26'h0000567);
      chkb(d15_o, 1'b1);
      chk16({8'h00, i_flash.cap_cmd}, 16'h0055);
   endtask
   task automatic t_prog();
      logic [15:0] q;
      set_mode(1'b0, 1'b0);
      xfer(1'b1, 1'b0, 27'h0000010, 16'h00A0, q);
      repeat (30) @(posedge mclk);
      chkb(dev_busy, 1'b0);
      set_mode(1'b0, 1'b1);
      xfer(1'b1, 1'b0, 27'h0000010, 16'h00A0, q);
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 400);
      set_mode(1'b0, 1'b0);
      xfer(1'b1, 1'b0, 27'h0100000, 16'h00A0, q);
      wait_busy(1'b1, 20);
      supply_low <= 1'b1;
      wait_busy(1'b0, 10);
      supply_low <= 1'b0;
   endtask
   task automatic t_hwreset();
      int n;
      n = 0;
      @(posedge mclk);
      reset_req <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (req_ready === 1'b1 && n < 5);
      if (n >= 5) bail();
      reset_req <= 1'b0;
      wait_up(n);
      chkb(n >= UP_MIN - 2, 1'b1);
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      int n;
      rstn = 1'b0;
      byte_mode = 1'b0;
      unprotect = 1'b0;
      reset_req = 1'b0;
      req_valid = 1'b0;
      supply_low = 1'b0;
      req = '0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      wait_up(n);
      chkb(n >= UP_MIN, 1'b1);
      t_read_word();
      t_read_byte();
      t_write();
      t_prog();
      t_hwreset();
      end_of_test();
   end
endmodule
